/* File: verilog/dmarb_pkg.sv */
// package: constants and carrier structs for the dma request arbiter
package dmarb_pkg;
   localparam int NCH       = 4;
   localparam int SEL_W     = 5;
   localparam int ADDR_W    = 20;
   localparam int CNT_W     = 16;
   localparam int NPERIPH   = 64;
   // bus clock (sampling period, once every BCLK_DIV rising clk edges) derived from clk
   localparam int CLK_HZ    = 50000000;
   localparam int BCLK_HZ   = 12500000;
   localparam int BCLK_DIV  = CLK_HZ / BCLK_HZ;
   localparam int DIV_W     = 8;
   localparam logic [SEL_W-1:0] SEL_SOFT = 5'h00;
   localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(BCLK_DIV - 1);

   typedef enum logic [1:0] {
      DMARB_IDLE,
      DMARB_HOLD,
      DMARB_XFER,
      DMARB_CPU
   } dmarb_state_t;

   // per channel software controls
   typedef struct packed {
      logic                en_wr;      // write strobe of control reg
      logic                en_val;     // written enable value
      logic                pend_wr0;   // write of 0 to pending flag
      logic                sw_req;     // software request bit written 1
      logic                src_fwd;
      logic                dst_fwd;
      logic                grp;        // source group bit
      logic [SEL_W-1:0]    sel;        // source select field
      logic [ADDR_W-1:0]   src_addr;
      logic [ADDR_W-1:0]   dst_addr;
      logic [CNT_W-1:0]    cnt_reload;
   } dmarb_ctl_t;

   typedef struct packed {
      logic                en;
      logic                pend;
      logic                load_due;   // reload owed at next start
      logic [ADDR_W-1:0]   ptr;
      logic [CNT_W-1:0]    cnt;
      logic                irq_q;      // previous sampled irq level
   } dmarb_ch_t;
endpackage

/* File: verilog/dmarb_arbiter.sv */
// dma channel request latching, reload and fixed priority arbitration
//********************************************************************
// Behaviour
//********************************************************************
// Behaviour
// (R1) on start after enable, pointer reloads from source or destination addr
// (R2) on that start the transfer counter loads from its reload value
// (R3) writing enable 1 while already 1 rearms the reload
// (R4) software writes enable and pending together, then checks reload
// (R5) each channel's trigger chosen by group bit and five-bit select
// (R6) every request event sets pending, enabled or not
// (R7) enabled channel's pending clears just before its transfer starts
// (R8) software may clear pending with 0; written 1 is ignored
// (R9) software clears pending after changing group or select
// (R10) software request bit sets pending for the software source
// (R11) peripheral source sets pending on rising peripheral irq flag
// (R12) requests sampled once per bus clock period, all set together
// (R13) fixed priority: channel 0 highest, channel 3 lowest
// (R14) after a transfer the cpu gets one bus access before next
// (R15) requests not counted; repeats merge into one pending flag
// (R16) each grant covers exactly one transfer unit
// (R17) bus taken from cpu by request/grant handshake before transfer
// (R18) each channel keeps its own enable, pending, select, pointer, count
module dmarb_arbiter
   import dmarb_pkg::*;
#(
   parameter int NUM_PERIPH = NPERIPH
) (
   input  wire logic                   clk,
   input  wire logic                   rst_n,
   input  wire dmarb_ctl_t [NCH-1:0]   ctl,
   input  wire logic [NUM_PERIPH-1:0]  periph_irq_flag,
   input  wire logic                   bus_grant,
   input  wire logic                   xfer_done,
   input  wire logic                   cpu_access_done,
   output logic                        bus_req,
   output logic                        xfer_start,
   output logic [1:0]                  xfer_ch,
   output logic [ADDR_W-1:0]           xfer_ptr,
   output logic [CNT_W-1:0]            xfer_cnt,
   output logic [NCH-1:0]              channel_enable_bit,
   output logic [NCH-1:0]              request_pending_flag,
   output logic [NCH*ADDR_W-1:0]       ptr_out,
   output logic [NCH*CNT_W-1:0]        cnt_out
);

   typedef struct packed {
      dmarb_state_t              st;
      dmarb_ch_t [NCH-1:0]       ch;
      logic [DIV_W-1:0]          div;
      logic [NUM_PERIPH-1:0]     irq_s1;
      logic [NUM_PERIPH-1:0]     irq_s2;
      logic [NCH-1:0]            sw_hold;  // sw request awaiting sample
      logic [1:0]                cur;
      logic                      start;
      logic [ADDR_W-1:0]         optr;
      logic [CNT_W-1:0]          ocnt;
   } dmarb_state_all_t;

   dmarb_state_all_t s_r;
   dmarb_state_all_t s_nxt;

   //*****************************************************************
   // helpers
   //*****************************************************************
   function automatic logic [1:0] prio_pick(input logic [NCH-1:0] m);
      logic [1:0] w;
      w = 2'h0;
      for (int i = NCH - 1; i >= 0; i--) begin
         if (m[i]) begin
            w = 2'(i); // R13
         end
      end
      return w;
   endfunction

   function automatic logic irq_pick(input logic [NUM_PERIPH-1:0] v,
                                     input logic g,
                                     input logic [SEL_W-1:0] s);
      logic [SEL_W:0] idx;
      idx = {g, s}; // R5
      irq_pick = 1'b0;
      if (int'(idx) < NUM_PERIPH) begin
         irq_pick = v[idx];
      end
   endfunction

   //*****************************************************************
   // next state
   //*****************************************************************
   logic           sample;
   logic [NCH-1:0] ready;
   logic           lvl;
   logic [NCH-1:0] set_now;
   logic [1:0]     win;

   always_comb begin
      s_nxt = s_r;
      s_nxt.start = 1'b0;
      s_nxt.irq_s1 = periph_irq_flag;
      s_nxt.irq_s2 = s_r.irq_s1;
      lvl = 1'b0;
      set_now = '0;
      // one sample per bus clock period
      sample = (s_r.div == DIV_LAST); // R12
      s_nxt.div = sample ? '0 : s_r.div + 1'b1;

      for (int i = 0; i < NCH; i++) begin
         // R18
         if (ctl[i].sw_req) begin
            s_nxt.sw_hold[i] = 1'b1; // R10
         end
         if (ctl[i].pend_wr0) begin
            s_nxt.ch[i].pend = 1'b0; // R8 R9
         end
         if (ctl[i].en_wr) begin
            s_nxt.ch[i].en = ctl[i].en_val;
            // rewriting 1 rearms the reload even when already set
            if (ctl[i].en_val) begin
               s_nxt.ch[i].load_due = 1'b1; // R3
            end
         end
         if (sample) begin
            lvl = irq_pick(s_r.irq_s2, ctl[i].grp, ctl[i].sel);
            s_nxt.ch[i].irq_q = lvl;
            // set wins over a same-cycle software clear
            if (ctl[i].sel == SEL_SOFT && !ctl[i].grp) begin
               if (s_r.sw_hold[i] || ctl[i].sw_req) begin
                  s_nxt.ch[i].pend = 1'b1; // R6 R10 R12 R15
                  s_nxt.sw_hold[i] = 1'b0;
                  set_now[i] = 1'b1;
               end
            end else if (lvl && !s_r.ch[i].irq_q) begin
               s_nxt.ch[i].pend = 1'b1; // R6 R11 R12 R15
               set_now[i] = 1'b1;
            end
         end
      end

      for (int i = 0; i < NCH; i++) begin
         ready[i] = s_r.ch[i].en && s_r.ch[i].pend;
      end
      win = prio_pick(ready); // R13

      unique case (s_r.st)
         DMARB_IDLE: begin
            if (|ready) begin
               s_nxt.st = DMARB_HOLD; // R17
            end
         end
         DMARB_HOLD: begin
            if (!(|ready)) begin
               s_nxt.st = DMARB_IDLE;
            end else if (bus_grant) begin
               s_nxt.cur = win; // R13
               // a request landing in the start cycle is kept
               if (!set_now[win]) begin
                  s_nxt.ch[win].pend = 1'b0; // R7 R15
               end
               s_nxt.start = 1'b1; // R17
               s_nxt.st = DMARB_XFER;
               if (s_r.ch[win].load_due) begin
                  s_nxt.ch[win].load_due = 1'b0;
                  s_nxt.ch[win].ptr = ctl[win].src_fwd ?
                                      ctl[win].src_addr :
                                      ctl[win].dst_addr; // R1
                  s_nxt.ch[win].cnt = ctl[win].cnt_reload; // R2
               end
               s_nxt.optr = s_nxt.ch[win].ptr;
               s_nxt.ocnt = s_nxt.ch[win].cnt;
            end
         end
         DMARB_XFER: begin
            // one unit per grant, then the bus goes back
            if (xfer_done) begin
               s_nxt.ch[s_r.cur].ptr = s_r.ch[s_r.cur].ptr + 1'b1;
               s_nxt.ch[s_r.cur].cnt = s_r.ch[s_r.cur].cnt - 1'b1;
               s_nxt.st = DMARB_CPU; // R16
            end
         end
         DMARB_CPU: begin
            if (cpu_access_done) begin
               s_nxt.st = DMARB_IDLE; // R14
            end
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   //*****************************************************************
   // outputs
   //*****************************************************************
   assign bus_req    = (s_r.st == DMARB_HOLD) || (s_r.st == DMARB_XFER);
   assign xfer_start = s_r.start;
   assign xfer_ch    = s_r.cur;
   assign xfer_ptr   = s_r.optr;
   assign xfer_cnt   = s_r.ocnt;

   always_comb begin
      for (int i = 0; i < NCH; i++) begin
         channel_enable_bit[i]   = s_r.ch[i].en;
         request_pending_flag[i] = s_r.ch[i].pend;
         ptr_out[i*ADDR_W +: ADDR_W] = s_r.ch[i].ptr;
         cnt_out[i*CNT_W +: CNT_W]   = s_r.ch[i].cnt;
      end
   end
endmodule

/* File: tb/dmarb_arbiter_asserts.sv */
// checker: bus handshake and pending flag timing of the arbiter
module dmarb_arbiter_chk
   import dmarb_pkg::*;
(
   input wire logic             clk,
   input wire logic             rst_n,
   input wire dmarb_ctl_t [NCH-1:0] ctl,
   input wire logic             bus_grant,
   input wire logic             xfer_done,
   input wire logic             cpu_access_done,
   input wire logic             bus_req,
   input wire logic             xfer_start,
   input wire logic [1:0]       xfer_ch,
   input wire logic [NCH-1:0]   channel_enable_bit,
   input wire logic [NCH-1:0]   request_pending_flag
);
   timeunit 1ns;
   timeprecision 1ns;
   // cpu access owed since the last finished unit
   logic owed_r;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         owed_r <= 1'b0;
      end else if (xfer_done && bus_req) begin
         owed_r <= 1'b1;
      end else if (cpu_access_done) begin
         owed_r <= 1'b0;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   AST_GRANT_FIRST: assert property (xfer_start |-> $past(bus_grant))
      else $error("start without grant");
   AST_GRANT_LAT: assert property
      ($rose(bus_grant) |-> ##[1:2] xfer_start)
      else $error("grant not followed by start");
   AST_PEND_WAS: assert property (xfer_start |->
      (($past(request_pending_flag) >> xfer_ch) & 4'h1) != 4'h0)
      else $error("start on channel not pending");
   AST_ONE_UNIT: assert property (xfer_done && bus_req |=> !bus_req)
      else $error("bus kept after unit");
   AST_START_PULSE: assert property
      (xfer_start |=> !xfer_start && bus_req)
      else $error("start not single pulse");
   AST_CPU_TURN: assert property (owed_r |-> !bus_req)
      else $error("bus taken before cpu access");
   AST_REQ_CAUSE: assert property ($rose(bus_req) |->
      (request_pending_flag & channel_enable_bit) != 4'h0)
      else $error("bus request without enabled pending");
   for (genvar i = 0; i < NCH; i++) begin : g_ch
      AST_PEND_HOLD: assert property ($fell(request_pending_flag[i]) |->
         (xfer_start && xfer_ch == i) || $past(ctl[i].pend_wr0))
         else $error("pending lost without service");
   end
endmodule
bind dmarb_arbiter dmarb_arbiter_chk u_chk (.clk, .rst_n, .ctl,
   .bus_grant, .xfer_done, .cpu_access_done, .bus_req, .xfer_start,
   .xfer_ch, .channel_enable_bit, .request_pending_flag);

/* File: tb/dmarb_cpu_model.sv */
// cpu partner: grants the bus, times one unit, then takes one access
module dmarb_cpu_model (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic bus_req,
   input  wire logic xfer_start,
   input  wire logic slow,
   output logic      bus_grant,
   output logic      xfer_done,
   output logic      cpu_access_done
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] wait_r;
   logic       busy_r;
   logic       own_r;
   wire  [3:0] dly = slow ? 4'h5 : 4'h1;
   wire        hit = (wait_r == dly);
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         {bus_grant, xfer_done, cpu_access_done, busy_r, own_r} <= '0;
         wait_r <= 4'h0;
      end else begin
         if (xfer_start | xfer_done | cpu_access_done) begin
            wait_r <= 4'h0;
         end else begin
            wait_r <= wait_r + 4'h1;
         end
         xfer_done <= busy_r & hit;
         cpu_access_done <= own_r & hit;
         if (xfer_start) busy_r <= 1'b1;
         if (own_r && hit) own_r <= 1'b0;
         // grant only on request; slow mode stretches every wait
         if (bus_req && !bus_grant && !busy_r && !own_r && hit) begin
            bus_grant <= 1'b1;
         end
         if (busy_r && hit) begin
            busy_r <= 1'b0;
            bus_grant <= 1'b0;
            own_r <= 1'b1;
         end
      end
   end
endmodule

/* File: tb/test_dmarb_arbiter.sv */
// testbench: dma request arbiter against a cpu bus partner
module test_dmarb_arbiter
   import dmarb_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic slow = 1'b0;
   dmarb_ctl_t [NCH-1:0] ctl = '0;
   logic [NPERIPH-1:0] irq = '0;
   logic bus_grant, xfer_done, cpu_done, bus_req, xfer_start;
   logic [1:0] xfer_ch;
   logic [ADDR_W-1:0] xfer_ptr;
   logic [CNT_W-1:0] xfer_cnt;
   logic [NCH-1:0] pend;
   logic [NCH-1:0] en_bits;
   logic [NCH*ADDR_W-1:0] ptr_all;
   logic [NCH*CNT_W-1:0] cnt_all;
   int fails = 0;
   int n_tests = 0;
   int cyc = 0;
   always #10 clk = ~clk;
   dmarb_arbiter u_dut (.clk, .rst_n, .ctl, .periph_irq_flag(irq),
      .bus_grant, .xfer_done, .cpu_access_done(cpu_done), .bus_req,
      .xfer_start, .xfer_ch, .xfer_ptr, .xfer_cnt,
      .channel_enable_bit(en_bits), .request_pending_flag(pend),
      .ptr_out(ptr_all), .cnt_out(cnt_all));
   dmarb_cpu_model u_cpu (.clk, .rst_n, .bus_req, .xfer_start, .slow,
      .bus_grant, .xfer_done, .cpu_access_done(cpu_done));
   task automatic summarize;
      if (fails == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // strobes for masked channels, one cycle wide
   task automatic pulse(input logic [3:0] m, input logic e, s, c);
      @(posedge clk);
      foreach (ctl[i]) ctl[i].en_wr <= m[i] & e;
      foreach (ctl[i]) ctl[i].sw_req <= m[i] & s;
      foreach (ctl[i]) ctl[i].pend_wr0 <= m[i] & c;
      @(posedge clk);
      foreach (ctl[i]) {ctl[i].en_wr, ctl[i].sw_req, ctl[i].pend_wr0} <= 3'h0;
   endtask
   task automatic next_start(input logic [1:0] ch, input logic [19:0] p,
                             input logic [15:0] n);
      int k;
      k = 0;
      @(posedge clk) #1;
      while (xfer_start !== 1'b1 && k < 60) begin
         @(posedge clk) #1;
         k++;
      end
      chk(xfer_start, 1'b1);
      chk(xfer_ch, ch);
      chk(xfer_ptr, p);
      chk(xfer_cnt, n);
   endtask
   task automatic t_prio;
      int k;
      k = 0;
      pulse(4'hf, 1'b1, 1'b0, 1'b0);
      pulse(4'hf, 1'b0, 1'b1, 1'b0);
      pulse(4'h2, 1'b0, 1'b1, 1'b0);
      for (int c = 0; c < 4; c++) begin
         if (c != 2) begin
            next_start(2'(c), 20'(c << 16), 16'h0008);
         end
      end
      chk(pend, 4'h4);
      repeat (40) begin
         @(posedge clk) #1;
         k += int'(xfer_start);
      end
      chk(k, 0);
      chk(en_bits, 4'hb);
      chk(ptr_all[19:0], 20'h00001);
      chk(cnt_all[15:0], 16'h0007);
      chk(cnt_all[47:32], 16'h0000);
      chk(cnt_all[63:48], 16'h0007);
      pulse(4'h4, 1'b0, 1'b0, 1'b1);
      @(posedge clk) #1;
      chk(pend, 4'h0);
   endtask
   task automatic t_reload;
      pulse(4'h8, 1'b0, 1'b1, 1'b0);
      next_start(2'h3, 20'h30001, 16'h0007);
      pulse(4'h8, 1'b1, 1'b1, 1'b0);
      next_start(2'h3, 20'h30000, 16'h0008);
      @(posedge clk);
      slow <= 1'b1;
      {ctl[2].en_val, ctl[2].src_fwd, ctl[2].dst_fwd} <= 3'h5;
      {ctl[2].grp, ctl[2].sel} <= 6'h23;
      pulse(4'h4, 1'b1, 1'b0, 1'b1);
      irq[6'h23] <= 1'b1;
      next_start(2'h2, 20'habcde, 16'h0008);
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 4000) begin
         fails++;
         summarize();
      end
   end
   initial begin
      foreach (ctl[i]) begin
         ctl[i].en_val = (i != 2);
         ctl[i].src_fwd = 1'b1;
         ctl[i].src_addr = 20'(i << 16);
         ctl[i].dst_addr = 20'habcde;
         ctl[i].cnt_reload = 16'h0008;
      end
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      t_prio();
      t_reload();
      summarize();
   end
endmodule
